// [src/usbpc_top.sv]
// Purpose: Transceiver control, line-state filter and auto-resume
//          cause capture behind an APB slave.
// Assumes: Single 250 MHz clock; line state and suspend inputs are
//          synchronous to it.
// Notes:   Zero-wait APB slave; read data is registered in setup.
// Overview of operation
// [R1] Writing one to the pulldown-disable bit turns off the two port pulldowns, which are on after reset.
// [R2] An automatic resume caused by bus reset sets the reset-cause flag, which holds until software writes it to zero.
// [R3] An automatic resume caused by K signalling sets the resume-cause flag, which holds until software writes it to zero.
// [R4] A line-state change passes the filter only after being stable for two to the power of the debounce field cycles.
// [R5] With the suspend-handling bit set hardware performs the resume, otherwise software polls the filtered line state.
// [R6] The three transceiver configuration pins follow the three-bit control field, zero after reset.
// [R7] Reserved bits of both control registers ignore writes and read as zero.
//
// The implementer's own choice: register access over APB.
`include "usbpc_params.svh"
`timescale 1ns/100ps
`default_nettype none

module usbpc_top (
  input  wire logic              ref_clk,       // 250 MHz clock
  input  wire logic              rst_n,         // Async reset, low
  input  wire logic              psel,          // APB select
  input  wire logic              penable,       // APB access phase
  input  wire logic              pwrite,        // APB write
  input  wire usbpc_pkg::usbpc_addr_t paddr,    // APB byte address
  input  wire usbpc_pkg::usbpc_word_t pwdata,   // APB write data
  output usbpc_pkg::usbpc_word_t prdata,        // APB read data
  output logic                   pready,        // APB ready
  output logic                   pslverr,       // Unmapped access
  input  wire usbpc_pkg::usbpc_ls_t line_state, // Raw line state
  input  wire logic              suspend_active, // Suspend state
  output usbpc_pkg::usbpc_ls_t   line_state_filt, // Filtered state
  output logic                   resume_req,    // Resume pulse
  output logic                   pulldown_disable, // Pulldowns off
  output logic [2:0]             transceiver_config_pins, // Conf
  output logic                   power_valid,   // Power valid bit
  output logic [7:0]             power_data,    // Power data
  output logic                   irq            // Interrupt level
);

  // ****************************************************
  // Reset release
  // ****************************************************
  logic                   rst_meta_n;
  logic                   rst_sync_n;
  logic                   hw_resume_en;
  logic [3:0]             db_log2;
  logic                   rst_cause;
  logic                   rsm_cause;
  usbpc_pkg::usbpc_ev_t   sts;
  usbpc_pkg::usbpc_ev_t   sts_mask;
  usbpc_pkg::usbpc_ev_t   events;
  usbpc_pkg::usbpc_ls_t   cand;
  usbpc_pkg::usbpc_ls_t   filt_prev;
  logic [15:0]            stable_cnt;
  logic [15:0]            span;
  logic                   ls_chg;
  logic                   auto_resume;
  logic                   set_rst;
  logic                   set_rsm;
  logic                   acc;
  logic                   wr_en;
  logic                   rd_setup;
  logic                   hit_any;
  usbpc_pkg::usbpc_word_t rd_mux;
  usbpc_pkg::usbpc_word_t next_prdata;

  // Release is synchronised so no flop sees a runt reset edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // ****************************************************
  // APB decode
  // ****************************************************
  function automatic logic hit(input usbpc_pkg::usbpc_addr_t a,
                               input usbpc_pkg::usbpc_addr_t off);
    hit = (a == off);
  endfunction

  // Zero-wait slave: every access completes in its first access cycle
  assign pready   = 1'b1;
  assign acc      = psel & penable;
  assign wr_en    = acc & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign hit_any  = hit(paddr, `USBPC_OFF_PWR)  |
                    hit(paddr, `USBPC_OFF_CTRL) |
                    hit(paddr, `USBPC_OFF_STS)  |
                    hit(paddr, `USBPC_OFF_MASK) |
                    hit(paddr, `USBPC_OFF_LINE);
  assign pslverr  = acc & ~hit_any;

  // ****************************************************
  // Power signalling register
  // ****************************************************
  // Only bits 8:0 are stored, the rest read as zero
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      power_valid <= `USBPC_CTRL_RST;
      power_data  <= `USBPC_PD_RST;
    end else if (wr_en && hit(paddr, `USBPC_OFF_PWR)) begin
      power_valid <= pwdata[`USBPC_PV_BIT];
      power_data  <= pwdata[`USBPC_PD_HI:0];
    end
  end

  // ****************************************************
  // Transceiver control register
  // ****************************************************
  // Pins are driven straight from the stored fields
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pulldown_disable        <= `USBPC_CTRL_RST;
      db_log2                 <= `USBPC_DB_RST;
      hw_resume_en            <= `USBPC_CTRL_RST;
      transceiver_config_pins <= `USBPC_CFG_RST;
    end else if (wr_en && hit(paddr, `USBPC_OFF_CTRL)) begin
      pulldown_disable        <= pwdata[`USBPC_PULLDN_BIT]; // [R1]
      db_log2                 <= pwdata[`USBPC_DB_HI:`USBPC_DB_LO];
      hw_resume_en            <= pwdata[`USBPC_HWRES_BIT];
      transceiver_config_pins <=
        pwdata[`USBPC_CFG_HI:`USBPC_CFG_LO];                 // [R6]
    end
  end

  // ****************************************************
  // Line-state filter
  // ****************************************************
  assign span = `USBPC_CNT_ONE << db_log2;

  // A new value restarts the count; it passes once held span cycles
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cand            <= `USBPC_LS_SE0;
      stable_cnt      <= `USBPC_CNT_ONE;
      line_state_filt <= `USBPC_LS_SE0;
    end else if (line_state != cand) begin
      cand       <= line_state;
      stable_cnt <= `USBPC_CNT_ONE;
    end else if (cand != line_state_filt) begin
      if (stable_cnt >= span) begin
        line_state_filt <= cand;                            // [R4]
      end else begin
        stable_cnt <= stable_cnt + `USBPC_CNT_ONE;
      end
    end
  end

  // Previous filtered value, used to spot a propagated change
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      filt_prev <= `USBPC_LS_SE0;
    end else begin
      filt_prev <= line_state_filt;
    end
  end

  assign ls_chg = (line_state_filt != filt_prev);

  // ****************************************************
  // Auto-resume and cause flags
  // ****************************************************
  // Software polls the filtered state when the hardware path is off
  assign auto_resume = ls_chg & suspend_active & hw_resume_en; // [R5]
  assign set_rst = auto_resume & (line_state_filt == `USBPC_LS_SE0);
  assign set_rsm = auto_resume & (line_state_filt == `USBPC_LS_K);

  // Resume pulse to the suspend controller
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      resume_req <= 1'b0;
    end else begin
      resume_req <= set_rst | set_rsm;                      // [R5]
    end
  end

  // Writing zero clears; a cause arriving in that cycle wins
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      rst_cause <= `USBPC_CTRL_RST;
      rsm_cause <= `USBPC_CTRL_RST;
    end else if (wr_en && hit(paddr, `USBPC_OFF_CTRL)) begin
      rst_cause <= set_rst |
                   (rst_cause & pwdata[`USBPC_RSTC_BIT]);  // [R2]
      rsm_cause <= set_rsm |
                   (rsm_cause & pwdata[`USBPC_RSMC_BIT]);  // [R3]
    end else begin
      rst_cause <= rst_cause | set_rst;                     // [R2]
      rsm_cause <= rsm_cause | set_rsm;                     // [R3]
    end
  end

  // ****************************************************
  // Interrupt status and mask
  // ****************************************************
  assign events[`USBPC_EV_RST]  = set_rst;
  assign events[`USBPC_EV_RSM]  = set_rsm;
  assign events[`USBPC_EV_LINE] = ls_chg;

  // Write one to clear; a new event in the same cycle is kept
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sts <= `USBPC_EV_RST_VAL;
    end else if (wr_en && hit(paddr, `USBPC_OFF_STS)) begin
      sts <= (sts & ~pwdata[`USBPC_EV_HI:0]) | events;
    end else begin
      sts <= sts | events;
    end
  end

  // Mask register, one enables the matching status bit
  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sts_mask <= `USBPC_EV_RST_VAL;
    end else if (wr_en && hit(paddr, `USBPC_OFF_MASK)) begin
      sts_mask <= pwdata[`USBPC_EV_HI:0];
    end
  end

  assign irq = |(sts & sts_mask);

  // ****************************************************
  // Read path
  // ****************************************************
  // Unstored bits stay zero, so reserved fields read as zero
  always_comb begin
    rd_mux = `USBPC_ZERO32;
    if (hit(paddr, `USBPC_OFF_PWR)) begin
      rd_mux[`USBPC_PV_BIT]   = power_valid;
      rd_mux[`USBPC_PD_HI:0]  = power_data;
    end
    if (hit(paddr, `USBPC_OFF_CTRL)) begin
      rd_mux[`USBPC_PULLDN_BIT]            = pulldown_disable; // [R7]
      rd_mux[`USBPC_RSTC_BIT]              = rst_cause;
      rd_mux[`USBPC_RSMC_BIT]              = rsm_cause;
      rd_mux[`USBPC_DB_HI:`USBPC_DB_LO]    = db_log2;
      rd_mux[`USBPC_HWRES_BIT]             = hw_resume_en;
      rd_mux[`USBPC_CFG_HI:`USBPC_CFG_LO]  = transceiver_config_pins;
    end
    if (hit(paddr, `USBPC_OFF_STS)) begin
      rd_mux[`USBPC_EV_HI:0] = sts;
    end
    if (hit(paddr, `USBPC_OFF_MASK)) begin
      rd_mux[`USBPC_EV_HI:0] = sts_mask;
    end
    if (hit(paddr, `USBPC_OFF_LINE)) begin
      rd_mux[1:0]            = line_state_filt;
      rd_mux[`USBPC_LN_SUSP] = suspend_active;
    end
  end

  // Captured in setup so data is from a flop by the access cycle
  always_comb begin
    next_prdata = prdata;
    if (rd_setup) begin
      next_prdata = rd_mux;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      prdata <= `USBPC_ZERO32;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ****************************************************
  // Assertions
  // ****************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_sync_n);

  property p_pulldown;
    wr_en && hit(paddr, `USBPC_OFF_CTRL) |=>
      pulldown_disable == $past(pwdata[`USBPC_PULLDN_BIT]);
  endproperty
  a_pulldown: assert property (p_pulldown) // [R1]
    else $error("pulldown disable does not follow write");

  property p_rst_cause;
    set_rst |=> rst_cause;
  endproperty
  a_rst_cause: assert property (p_rst_cause) // [R2]
    else $error("reset cause flag not set after bus reset resume");

  // Only a written zero may take a cause flag down
  property p_rst_hold;
    rst_cause && !(wr_en && hit(paddr, `USBPC_OFF_CTRL) &&
      !pwdata[`USBPC_RSTC_BIT]) |=> rst_cause;
  endproperty
  a_rst_hold: assert property (p_rst_hold) // [R2]
    else $error("reset cause flag dropped without a zero write");

  property p_rsm_hold;
    rsm_cause && !(wr_en && hit(paddr, `USBPC_OFF_CTRL) &&
      !pwdata[`USBPC_RSMC_BIT]) |=> rsm_cause;
  endproperty
  a_rsm_hold: assert property (p_rsm_hold) // [R3]
    else $error("resume cause flag dropped without a zero write");

  property p_rsm_cause;
    $rose(rsm_cause) |-> $past(set_rsm) &&
      $past(line_state_filt) == `USBPC_LS_K;
  endproperty
  a_rsm_cause: assert property (p_rsm_cause) // [R3]
    else $error("resume cause flag set without K resume");

  property p_filter;
    ls_chg |-> $past(line_state) == line_state_filt &&
      $past(stable_cnt) >= $past(span);
  endproperty
  a_filter: assert property (p_filter) // [R4]
    else $error("line state passed before stable time");

  property p_hw_resume;
    resume_req |-> $past(hw_resume_en) && $past(suspend_active);
  endproperty
  a_hw_resume: assert property (p_hw_resume) // [R5]
    else $error("resume request without hardware handling");

  property p_config;
    wr_en && hit(paddr, `USBPC_OFF_CTRL) |=> transceiver_config_pins
      == $past(pwdata[`USBPC_CFG_HI:`USBPC_CFG_LO]);
  endproperty
  a_config: assert property (p_config) // [R6]
    else $error("config pins do not follow control field");

  property p_reserved;
    acc && !pwrite && hit(paddr, `USBPC_OFF_CTRL) |->
      prdata[31:19] == 13'h0 && prdata[17:14] == 4'h0 &&
      prdata[3:0] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) // [R7]
    else $error("reserved control bits read nonzero");

  property p_irq;
    events != 3'h0 ##1 (sts_mask & $past(events)) != 3'h0 |-> irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("unmasked event did not raise interrupt");

endmodule

`default_nettype wire

// [shared/usbpc_params.svh]
// Purpose: Offsets, field positions and reset values of the
//          transceiver control and resume slice.
// Assumes: 32-bit APB data, 12-bit byte address.
// Notes:   Definitions only.
`ifndef USBPC_PARAMS_SVH
`define USBPC_PARAMS_SVH

// ****************************************************
// Register byte offsets
// ****************************************************
`define USBPC_OFF_PWR      12'h03C
`define USBPC_OFF_CTRL     12'h040
`define USBPC_OFF_STS      12'h044
`define USBPC_OFF_MASK     12'h048
`define USBPC_OFF_LINE     12'h04C

// ****************************************************
// Field positions
// ****************************************************
`define USBPC_PV_BIT       8
`define USBPC_PD_HI        7
`define USBPC_PULLDN_BIT   18
`define USBPC_RSTC_BIT     13
`define USBPC_RSMC_BIT     12
`define USBPC_DB_HI        11
`define USBPC_DB_LO        8
`define USBPC_HWRES_BIT    7
`define USBPC_CFG_HI       6
`define USBPC_CFG_LO       4
`define USBPC_EV_RST       0
`define USBPC_EV_RSM       1
`define USBPC_EV_LINE      2
`define USBPC_EV_HI        2
`define USBPC_LN_SUSP      2

// ****************************************************
// Reset values and constants
// ****************************************************
`define USBPC_ZERO32       32'h0000_0000
`define USBPC_CTRL_RST     1'b0
`define USBPC_DB_RST       4'h0
`define USBPC_CFG_RST      3'h0
`define USBPC_PD_RST       8'h00
`define USBPC_EV_RST_VAL   3'h0
`define USBPC_CNT_ONE      16'h0001
`define USBPC_LS_SE0       2'h0
`define USBPC_LS_K         2'h2

`endif

// [shared/usbpc_pkg.sv]
// Purpose: Shared types of the transceiver control slice.
// Assumes: Used with usbpc_params.svh.
// Notes:   Types only; offsets live in the header.
package usbpc_pkg;
  typedef logic [31:0] usbpc_word_t;
  typedef logic [11:0] usbpc_addr_t;
  typedef logic [1:0]  usbpc_ls_t;
  typedef logic [2:0]  usbpc_ev_t;
endpackage

// [testbench/usbpc_phy_model.sv]
// Purpose: Transceiver and suspend controller stand-in for the bench.
// Assumes: Bench changes the wanted values just after a rising edge.
// Notes:   No analog effects; pulldown and config pins are not modelled.
`timescale 1ns/100ps
`default_nettype none

module usbpc_phy_model (
  input  wire logic [1:0] want_ls,        // Line state to present
  input  wire logic       want_susp,      // Suspend level to present
  output logic [1:0]      line_state,     // Raw line state out
  output logic            suspend_active  // Suspend level out
);
  // Straight wires: the design's own filter must absorb any bounce
  assign line_state     = want_ls;
  // Software polls the filtered state when hardware resume is off
  assign suspend_active = want_susp;
endmodule

`default_nettype wire

// [testbench/usb_phy_control_resume_bench.sv]
// Purpose: Self-checking bench for the transceiver control slice.
// Assumes: Zero-wait APB slave; debounce exponent set to DB in tests.
// Notes:   Random register data comes from a 16-bit LFSR seeded at 68.
`timescale 1ns/100ps
`default_nettype none
`include "usbpc_params.svh"

module usb_phy_control_resume_bench;
  localparam int DB = 2; // Short window keeps the filter tests quick
  logic                   ref_clk, rst_n, psel, penable, pwrite;
  logic                   pready, pslverr, perr, resume_req, irq;
  logic                   pulldown_disable, power_valid, susp, sa;
  logic [1:0]             want_ls, ls, filt;
  logic [2:0]             cfg;
  logic [7:0]             pdata;
  logic [15:0]            lfsr;
  usbpc_pkg::usbpc_addr_t paddr;
  usbpc_pkg::usbpc_word_t pwdata, prdata, rd, w, ctrl;
  int                     err_total, n_checks;

  usbpc_top DUT (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .line_state(ls),
    .suspend_active(sa), .line_state_filt(filt), .resume_req(resume_req),
    .pulldown_disable(pulldown_disable), .transceiver_config_pins(cfg),
    .power_valid(power_valid), .power_data(pdata), .irq(irq));
  usbpc_phy_model PHY (.want_ls(want_ls), .want_susp(susp),
    .line_state(ls), .suspend_active(sa));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Flags keep only where a one is written; reserved bits drop
  function automatic usbpc_pkg::usbpc_word_t exp_ctrl(
    input usbpc_pkg::usbpc_word_t wr, old);
    return (wr & 32'h0004_0FF0) | (old & wr & 32'h0000_3000);
  endfunction
  task automatic rnd();
    lfsr = lfsr_next(lfsr);
    w = {lfsr, lfsr_next(lfsr)};
    lfsr = lfsr_next(lfsr);
  endtask
  task automatic chk(input usbpc_pkg::usbpc_word_t g, e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // One APB transfer; waits for pready, no fixed latency assumed
  task automatic apb(input logic wr, input usbpc_pkg::usbpc_addr_t a,
                     input usbpc_pkg::usbpc_word_t d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    rd = prdata;
    perr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // Hold a new line value and watch it pass at exactly 2^DB+1 edges
  task automatic step(input logic [1:0] v, old, input logic hw);
    @(posedge ref_clk);
    want_ls <= v;
    repeat (1 << DB) @(posedge ref_clk);
    #1 chk(32'(filt), 32'(old));
    @(posedge ref_clk);
    #1 chk(32'(filt), 32'(v));
    @(posedge ref_clk);
    #1 chk(32'(resume_req), 32'(hw && v != 2'h1));
  endtask
  task automatic end_sim();
    if (err_total == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    err_total = err_total + 1;
    end_sim();
  end
  initial begin
    {rst_n, psel, penable, pwrite, susp} = 5'h00;
    paddr = '0;
    pwdata = '0;
    want_ls = 2'h1;
    lfsr = 16'h0044;
    ctrl = '0;
    err_total = 0;
    n_checks = 0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    apb(1'b0, `USBPC_OFF_PWR, '0);
    chk(rd, '0);
    apb(1'b0, `USBPC_OFF_CTRL, '0);
    chk(rd, '0);
    for (int i = 0; i < 6; i++) begin
      rnd();
      apb(1'b1, `USBPC_OFF_CTRL, w);
      ctrl = exp_ctrl(w, ctrl);
      chk(32'({pulldown_disable, cfg}), 32'({w[18], w[6:4]}));
      apb(1'b0, `USBPC_OFF_CTRL, '0);
      chk(rd, ctrl);
      rnd();
      apb(1'b1, `USBPC_OFF_PWR, w);
      chk(32'({power_valid, pdata}), w & 32'h0000_01FF);
      apb(1'b0, `USBPC_OFF_PWR, '0);
      chk(rd, w & 32'h0000_01FF);
    end
    // Unmapped place answers with an error and zero data
    apb(1'b0, 12'h100, '0);
    chk({rd[31:1], perr}, 32'h0000_0001);
    ctrl = 32'h0000_0200;
    apb(1'b1, `USBPC_OFF_CTRL, ctrl);
    step(2'h2, 2'h1, 1'b0);
    step(2'h1, 2'h2, 1'b0);
    @(posedge ref_clk);
    susp <= 1'b1;
    ctrl = 32'h0000_0280;
    apb(1'b1, `USBPC_OFF_CTRL, ctrl);
    // A K shorter than the window must never surface
    @(posedge ref_clk);
    want_ls <= 2'h2;
    repeat (2) @(posedge ref_clk);
    want_ls <= 2'h1;
    repeat (8) @(posedge ref_clk);
    #1 chk(32'(filt), 32'h0000_0001);
    step(2'h2, 2'h1, 1'b1);
    apb(1'b0, `USBPC_OFF_CTRL, '0);
    chk(rd, 32'h0000_1280);
    step(2'h1, 2'h2, 1'b1);
    step(2'h0, 2'h1, 1'b1);
    apb(1'b0, `USBPC_OFF_CTRL, '0);
    chk(rd, 32'h0000_3280);
    // Writing one keeps a flag, writing zero clears it
    apb(1'b1, `USBPC_OFF_CTRL, 32'h0000_2280);
    apb(1'b0, `USBPC_OFF_CTRL, '0);
    chk(rd, 32'h0000_2280);
    apb(1'b1, `USBPC_OFF_CTRL, 32'h0000_0200);
    step(2'h2, 2'h0, 1'b0);
    apb(1'b0, `USBPC_OFF_CTRL, '0);
    chk(rd, 32'h0000_0200);
    apb(1'b0, `USBPC_OFF_LINE, '0);
    chk(rd, 32'h0000_0006);
    // Line status is read only, a write must leave it alone
    apb(1'b1, `USBPC_OFF_LINE, 32'hFFFF_FFFF);
    apb(1'b0, `USBPC_OFF_LINE, '0);
    chk(rd, 32'h0000_0006);
    // Events stay pending but silent until unmasked
    apb(1'b0, `USBPC_OFF_STS, '0);
    chk(rd, 32'h0000_0007);
    chk(32'(irq), '0);
    apb(1'b1, `USBPC_OFF_MASK, 32'h0000_0002);
    chk(32'(irq), 32'h0000_0001);
    apb(1'b1, `USBPC_OFF_STS, 32'h0000_0007);
    apb(1'b0, `USBPC_OFF_STS, '0);
    chk(rd, '0);
    chk(32'(irq), '0);
    end_sim();
  end
endmodule

`default_nettype wire
